// ---- logic/spch_top.sv ----
/*
 * Serial port command handler: parses command frames from a byte stream,
 * drives port outputs and answers with handshake, data or error bytes.
 * Assumes a byte source with valid/ready and a byte sink with valid/ready;
 * the expander bus transaction itself is handled outside this block.
 */
`timescale 1ns/1ps
module spch_top (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire logic              rx_valid,
	input  wire logic [7:0]        rx_data,
	output logic                   rx_ready,
	output logic                   tx_valid,
	output logic      [7:0]        tx_data,
	input  wire logic              tx_ready,
	input  wire logic              motion_busy,
	input  wire logic              ref_req,
	input  wire spch_pkg::spch_in_s port_in,
	output spch_pkg::spch_out_s    port_out,
	output logic                   exp_wr,
	output logic                   test_mode,
	output logic                   home_start,
	output logic                   ref_capture,
	output logic      [3:0]        limit_block,
	output logic      [3:0]        limit_seen
);
	import spch_pkg::*;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_DEV  = 5'b00010,
		ST_ARG1 = 5'b00100,
		ST_ARG2 = 5'b01000,
		ST_SEND = 5'b10000
	} spch_state_e;

	spch_state_e            state;
	spch_state_e            next_state;
	logic [7:0]             device_number;
	logic [7:0]             cmd;
	logic                   dev_match;
	logic                   bad_char;
	logic                   have_comma;
	logic                   exec;
	logic [7:0]             reply [REPLY_N];
	logic [2:0]             reply_len;
	logic [2:0]             tx_idx;
	logic                   last_err;
	logic [7:0]             frame_cnt;
	logic [ARG_W-1:0]       dev_val;
	logic [ARG_W-1:0]       arg1;
	logic [ARG_W-1:0]       arg2;
	logic                   dev_ovf, arg1_ovf, arg2_ovf;
	logic                   dev_seen, arg1_seen, arg2_seen;
	logic                   take, is_digit, is_cr, frame_clr;
	logic [3:0]             digit;
	logic                   rd_ok, wr_ok, test_ok;
	logic [7:0]             rd_byte;
	logic                   args_ok;

	// ----------------------------------------------------------------
	// Frame parsing
	// ----------------------------------------------------------------
	assign take      = rx_valid & rx_ready;
	assign is_digit  = (rx_data >= CH_DIGIT0) && (rx_data <= CH_DIGIT9);
	assign is_cr     = rx_data == CH_CR;
	assign digit     = 4'(rx_data - CH_DIGIT0);
	assign frame_clr = take && rx_data == CH_OPEN;

	spch_dec_acc #(.W(ARG_W)) u_dev (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (frame_clr),
		.step    (take && state == ST_DEV && is_digit),
		.digit   (digit),
		.value   (dev_val),
		.ovf     (dev_ovf),
		.seen    (dev_seen)
	);

	spch_dec_acc #(.W(ARG_W)) u_arg1 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (frame_clr),
		.step    (take && state == ST_ARG1 && is_digit),
		.digit   (digit),
		.value   (arg1),
		.ovf     (arg1_ovf),
		.seen    (arg1_seen)
	);

	spch_dec_acc #(.W(ARG_W)) u_arg2 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.clr     (frame_clr),
		.step    (take && state == ST_ARG2 && is_digit),
		.digit   (digit),
		.value   (arg2),
		.ovf     (arg2_ovf),
		.seen    (arg2_seen)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (frame_clr)
					next_state = ST_DEV;
			end
			ST_DEV: begin
				if (frame_clr)
					next_state = ST_DEV;
				else if (take && is_cr)
					next_state = ST_IDLE;
				else if (take && !is_digit)
					next_state = ST_ARG1;
			end
			ST_ARG1, ST_ARG2: begin
				if (frame_clr)
					next_state = ST_DEV;
				else if (take && is_cr)
					next_state = dev_match ? ST_SEND : ST_IDLE;
				else if (take && state == ST_ARG1 && rx_data == CH_COMMA)
					next_state = ST_ARG2;
			end
			ST_SEND: begin
				if (tx_valid && tx_ready && tx_idx == reply_len - 3'd1)
					next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// Input is stalled while a reply drains, so no byte is lost
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rx_ready <= 1'b0;
		else
			rx_ready <= next_state != ST_SEND;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd        <= 8'h00;
			dev_match  <= 1'b0;
			bad_char   <= 1'b0;
			have_comma <= 1'b0;
		end else if (frame_clr) begin
			bad_char   <= 1'b0;
			have_comma <= 1'b0;
		end else if (take && state == ST_DEV && !is_digit && !is_cr) begin
			cmd       <= rx_data;
			dev_match <= dev_seen && !dev_ovf
				&& dev_val == ARG_W'(device_number);
		end else if (take && state == ST_ARG1 && rx_data == CH_COMMA) begin
			have_comma <= 1'b1;
		end else if (take && (state == ST_ARG1 || state == ST_ARG2)
				&& !is_digit && !is_cr) begin
			bad_char <= 1'b1;
		end
	end

	assign exec = take && is_cr && dev_match
		&& (state == ST_ARG1 || state == ST_ARG2);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	assign args_ok = !bad_char && arg1_seen && !arg1_ovf;

	always_comb begin
		rd_ok   = 1'b1;
		rd_byte = 8'h00;
		if (arg1 == PORT_USER || arg1 == PORT_ALT_RD)
			rd_byte = port_in.user;
		else if (arg1 == PORT_COVER)
			rd_byte = {7'h00, port_in.cover_closed};
		else if (arg1 == PORT_SPIN)
			rd_byte = {7'h00, port_out.spindle};
		else if (arg1 == PORT_MOTOR)
			rd_byte = {7'h00, port_out.motor};
		else if (arg1 == PORT_EXP)
			rd_byte = port_in.expander;
		else if (arg1 == PORT_USER6)
			rd_byte = {3'h0, port_in.user6};
		else
			rd_ok = 1'b0;
		rd_ok = rd_ok && args_ok && !have_comma && !motion_busy;
	end

	always_comb begin
		wr_ok = args_ok && have_comma && arg2_seen && !arg2_ovf
			&& !motion_busy;
		if (arg1 == PORT_COVER || arg1 == PORT_SPIN || arg1 == PORT_MOTOR)
			wr_ok = wr_ok && arg2 <= VAL_BIT;
		else if (arg1 == PORT_USER || arg1 == PORT_ALT_WR
				|| arg1 == PORT_ANALOG || arg1 == PORT_EXP
				|| arg1 == PORT_USER6)
			wr_ok = wr_ok && arg2 <= VAL_BYTE;
		else
			wr_ok = 1'b0;
	end

	assign test_ok = args_ok && !have_comma && arg1 <= VAL_BIT
		&& !motion_busy;

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'hA) ? CH_DIGIT0 + 8'(n) : 8'h37 + 8'(n);
	endfunction : hex_char

	// ----------------------------------------------------------------
	// Reply assembly and transmit
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < REPLY_N; i++)
				reply[i] <= 8'h00;
			reply_len <= 3'd1;
			last_err  <= 1'b0;
		end else if (exec) begin
			reply[0]  <= CH_ERR;
			reply_len <= 3'd1;
			last_err  <= 1'b1;
			if (cmd == CMD_RD && rd_ok) begin
				reply[0]  <= CH_HS;
				reply[1]  <= hex_char(rd_byte[7:4]);
				reply[2]  <= hex_char(rd_byte[3:0]);
				reply_len <= 3'd3;
				last_err  <= 1'b0;
			end else if ((cmd == CMD_WR && wr_ok)
					|| (cmd == CMD_TEST && test_ok)) begin
				reply[0] <= CH_HS;
				last_err <= 1'b0;
			end else if (cmd == CMD_STAT_IN || cmd == CMD_STAT_LM) begin
				reply[0]  <= cmd == CMD_STAT_IN ? TXT_IN : TXT_LM;
				reply[1]  <= cmd == CMD_STAT_IN
					? hex_char(port_in.user[7:4]) : 8'h30;
				reply[2]  <= cmd == CMD_STAT_IN
					? hex_char(port_in.user[3:0])
					: hex_char(port_in.limit);
				reply[3]  <= CH_CR;
				reply[4]  <= CH_LF;
				reply[5]  <= CH_HS;
				reply_len <= 3'd6;
				last_err  <= 1'b0;
			end
		end
	end

	// Data is loaded one cycle after the reply is built
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_idx   <= 3'd0;
		end else if (state != ST_SEND) begin
			tx_valid <= 1'b0;
			tx_idx   <= 3'd0;
		end else if (!tx_valid) begin
			tx_valid <= 1'b1;
			tx_data  <= reply[tx_idx];
		end else if (tx_ready) begin
			if (tx_idx == reply_len - 3'd1) begin
				tx_valid <= 1'b0;
			end else begin
				tx_idx  <= tx_idx + 3'd1;
				tx_data <= reply[tx_idx + 3'd1];
			end
		end
	end

	// ----------------------------------------------------------------
	// Port outputs and test mode
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_out <= '{user: USER_RST, default: '0};
			exp_wr   <= 1'b0;
		end else begin
			exp_wr <= 1'b0;
			if (exec && cmd == CMD_WR && wr_ok) begin
				if (arg1 == PORT_USER || arg1 == PORT_ALT_WR)
					port_out.user <= (port_out.user & USER_RSV)
						| (arg2[7:0] & ~USER_RSV);
				if (arg1 == PORT_COVER)
					port_out.cover_release <= arg2[0];
				if (arg1 == PORT_SPIN)
					port_out.spindle <= arg2[0];
				if (arg1 == PORT_MOTOR)
					port_out.motor <= arg2[0];
				if (arg1 == PORT_ANALOG)
					port_out.analog <= arg2[7:0];
				if (arg1 == PORT_EXP) begin
					port_out.expander <= arg2[7:0];
					exp_wr            <= 1'b1;
				end
				if (arg1 == PORT_USER6)
					port_out.user6 <= arg2[7:0] & USER6_WMASK;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			test_mode <= 1'b0;
		else if (exec && cmd == CMD_TEST && test_ok)
			test_mode <= arg1[0];
	end

	// Homing is replaced by a position capture while testing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			home_start  <= 1'b0;
			ref_capture <= 1'b0;
		end else begin
			home_start  <= ref_req && !test_mode;
			ref_capture <= ref_req && test_mode;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			limit_block <= 4'h0;
			limit_seen  <= 4'h0;
		end else begin
			limit_seen  <= port_in.limit;
			limit_block <= port_in.limit & {4{~test_mode}};
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite register slave, zero wait states
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	logic       wr_pend;
	logic [7:0] wr_addr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= hsel && htrans[1] && hready && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			device_number <= DEVNUM_RST;
		else if (wr_pend && wr_addr == REG_CFG)
			device_number <= hwdata[7:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			frame_cnt <= 8'h00;
		else if (exec)
			frame_cnt <= frame_cnt + 8'h01;
	end

	// Read data is registered in the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hsel && htrans[1] && hready && !hwrite) begin
			unique case (haddr[7:0])
				REG_CFG:    hrdata <= {24'h000000, device_number};
				REG_STATUS: hrdata <= {16'h0000, frame_cnt, 4'h0,
					limit_seen[0], last_err, motion_busy, test_mode};
				REG_PORTS:  hrdata <= {port_out.user6, port_out.analog,
					port_out.user, 5'h00, port_out.motor,
					port_out.spindle, port_out.cover_release};
				REG_INPUTS: hrdata <= {8'h00, port_in.expander,
					port_in.user, 3'h0, port_in.user6};
				default:    hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_read_busy_err: assert property (
		exec && cmd == CMD_RD && motion_busy |=> reply[0] == CH_ERR
		##1 state == ST_SEND && tx_valid && tx_data == CH_ERR)
		else $error("read during motion not refused");
	a_read_hs_data: assert property (
		exec && cmd == CMD_RD && rd_ok
		|=> reply[0] == CH_HS && reply_len == 3'd3)
		else $error("read reply lacks handshake and two chars");
	a_write_hold: assert property (
		exec && cmd == CMD_WR && !wr_ok |=> $stable(port_out) && !exp_wr)
		else $error("rejected write changed outputs");
	a_user_rsv_keep: assert property (
		(port_out.user & USER_RSV) == ($past(port_out.user) & USER_RSV))
		else $error("reserved user bits changed");
	a_test_set: assert property (
		exec && cmd == CMD_TEST && test_ok
		|=> test_mode == $past(arg1[0]) && reply[0] == CH_HS)
		else $error("test mode not applied");
	a_test_busy: assert property (
		exec && cmd == CMD_TEST && motion_busy |=> $stable(test_mode))
		else $error("test mode changed during motion");
	a_ref_capture: assert property (
		ref_req && test_mode |=> ref_capture && !home_start)
		else $error("homing started in test mode");
	a_limit_pass: assert property (
		test_mode |=> limit_block == 4'h0)
		else $error("limit blocks motion in test mode");
	a_foreign_drop: assert property (
		take && is_cr && !dev_match && state == ST_ARG1
		|=> state == ST_IDLE && !tx_valid ##1 !tx_valid)
		else $error("foreign frame answered");
	a_status_tail: assert property (
		exec && (cmd == CMD_STAT_IN || cmd == CMD_STAT_LM)
		|=> reply_len == 3'd6 && reply[5] == CH_HS)
		else $error("status text not closed by handshake");

endmodule : spch_top

// ---- shared/spch_pkg.sv ----
/*
 * Shared constants and carriers for the serial port command handler.
 * Assumes an 8-bit byte stream link and an AHB-Lite register bus.
 */
package spch_pkg;

	// ----------------------------------------------------------------
	// Link characters
	// ----------------------------------------------------------------
	localparam logic [7:0] CH_OPEN     = 8'h40;
	localparam logic [7:0] CH_CR       = 8'h0D;
	localparam logic [7:0] CH_LF       = 8'h0A;
	localparam logic [7:0] CH_COMMA    = 8'h2C;
	localparam logic [7:0] CH_DIGIT0   = 8'h30;
	localparam logic [7:0] CH_DIGIT9   = 8'h39;
	localparam logic [7:0] CH_HS       = 8'h30;
	localparam logic [7:0] CH_ERR      = 8'h45;
	localparam logic [7:0] CMD_RD      = 8'h62;
	localparam logic [7:0] CMD_WR      = 8'h42;
	localparam logic [7:0] CMD_TEST    = 8'h54;
	localparam logic [7:0] CMD_STAT_IN = 8'h48;
	localparam logic [7:0] CMD_STAT_LM = 8'h68;
	localparam logic [7:0] TXT_IN      = 8'h49;
	localparam logic [7:0] TXT_LM      = 8'h4C;

	// ----------------------------------------------------------------
	// Port numbers and values
	// ----------------------------------------------------------------
	localparam int          ARG_W       = 17;
	localparam logic [16:0] PORT_USER   = 17'h00000;
	localparam logic [16:0] PORT_COVER  = 17'h00001;
	localparam logic [16:0] PORT_SPIN   = 17'h00002;
	localparam logic [16:0] PORT_MOTOR  = 17'h00003;
	localparam logic [16:0] PORT_ANALOG = 17'h00004;
	localparam logic [16:0] PORT_EXP    = 17'h00005;
	localparam logic [16:0] PORT_USER6  = 17'h00006;
	localparam logic [16:0] PORT_ALT_RD = 17'h0FFFB;
	localparam logic [16:0] PORT_ALT_WR = 17'h0FFF9;
	localparam logic [16:0] VAL_BYTE    = 17'h000FF;
	localparam logic [16:0] VAL_BIT     = 17'h00001;
	localparam logic [7:0]  USER_RSV    = 8'h87;
	localparam logic [7:0]  USER6_WMASK = 8'hF0;
	localparam logic [7:0]  USER_RST    = 8'h00;
	localparam logic [7:0]  DEVNUM_RST  = 8'h00;
	localparam int          REPLY_N     = 6;

	// ----------------------------------------------------------------
	// Register map (byte offsets, low address byte decoded)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CFG    = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PORTS  = 8'h08;
	localparam logic [7:0] REG_INPUTS = 8'h0C;

	typedef struct packed {
		logic [7:0] user;
		logic       cover_release;
		logic       spindle;
		logic       motor;
		logic [7:0] analog;
		logic [7:0] expander;
		logic [7:0] user6;
	} spch_out_s;

	typedef struct packed {
		logic [7:0] user;
		logic       cover_closed;
		logic [7:0] expander;
		logic [4:0] user6;
		logic [3:0] limit;
	} spch_in_s;

endpackage : spch_pkg

// ---- logic/spch_dec_acc.sv ----
/*
 * Decimal digit accumulator for one numeric field of a command frame.
 * Assumes digits arrive as binary 0..9 with a one-cycle step strobe.
 */
`timescale 1ns/1ps
module spch_dec_acc #(
	parameter int W = 17
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         clr,
	input  wire logic         step,
	input  wire logic [3:0]   digit,
	output logic      [W-1:0] value,
	output logic              ovf,
	output logic              seen
);
	logic [W+3:0] next_value;

	assign next_value = {4'h0, value} * (W+4)'(10) + (W+4)'(digit);

	// Overflow is sticky so an over-long number can never alias a port
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value <= '0;
			ovf   <= 1'b0;
			seen  <= 1'b0;
		end else if (clr) begin
			value <= '0;
			ovf   <= 1'b0;
			seen  <= 1'b0;
		end else if (step) begin
			value <= next_value[W-1:0];
			ovf   <= ovf | (|next_value[W+3:W]);
			seen  <= 1'b1;
		end
	end

endmodule : spch_dec_acc

// ---- test/spch_host.sv ----
/*
 * Host computer model for the serial command handler: sends command
 * frames byte by byte and collects every reply byte in a queue.
 * Assumes the device takes a byte on an edge with rx_valid and rx_ready.
 */
`timescale 1ns/1ps
module spch_host (
	input  wire logic       hclk,
	output logic            rx_valid,
	output logic      [7:0] rx_data,
	input  wire logic       rx_ready,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] q[$];
	bit         slow = 1'b0;

	initial begin
		rx_valid = 1'b0;
		rx_data  = 8'h00;
		tx_ready = 1'b0;
	end

	// Slow mode holds tx_ready low on every other cycle
	always @(posedge hclk) begin
		tx_ready <= slow ? ~tx_ready : 1'b1;
	end

	// Unbounded queue stands for a large enough receive buffer
	always @(posedge hclk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
			q.push_back(tx_data);
	end

	// Byte held until taken; afterwards the line shows the inverse
	task send(input string s);
		@(posedge hclk);
		for (int i = 0; i < s.len(); i++) begin
			rx_valid <= 1'b1;
			rx_data  <= s[i];
			do @(posedge hclk); while (rx_ready !== 1'b1);
		end
		rx_valid <= 1'b0;
		rx_data  <= ~s[s.len()-1];
	endtask : send
endmodule : spch_host

// ---- test/spch_top_tb.sv ----
/*
 * Self-checking bench for the serial port command handler.
 * Assumes a zero-wait AHB-Lite slave and the host model as link partner.
 */
`timescale 1ns/1ps
module spch_top_tb;
	import spch_pkg::*;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        exp_wr;
	logic        rx_valid;
	logic [7:0]  rx_data;
	logic        rx_ready;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_ready;
	logic        motion_busy = 1'b0;
	logic        ref_req = 1'b0;
	spch_in_s    port_in = '0;
	spch_out_s   port_out;
	logic        test_mode;
	logic        home_start;
	logic        ref_capture;
	logic [3:0]  limit_block;
	logic [3:0]  limit_seen;
	logic [31:0] rd;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          exp_pulses = 0;

	always #5 hclk = ~hclk;

	// Expander write strobes last one cycle, so they are counted here
	always @(posedge hclk) begin
		if (exp_wr === 1'b1)
			exp_pulses++;
	end

	spch_top i_spch_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .motion_busy(motion_busy),
		.ref_req(ref_req), .port_in(port_in), .port_out(port_out),
		.exp_wr(exp_wr), .test_mode(test_mode), .home_start(home_start),
		.ref_capture(ref_capture), .limit_block(limit_block),
		.limit_seen(limit_seen));

	spch_host i_spch_host (.hclk(hclk), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task ahb(input bit wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check(hresp, 1'b0);
	endtask : ahb

	// An empty expectation waits a while and demands silence
	task cmd(input string f, input string e);
		int n;
		i_spch_host.send(f);
		n = 0;
		while ((i_spch_host.q.size() < e.len() || e.len() == 0) && n < 400) begin
			@(posedge hclk);
			n++;
			if (e.len() == 0 && n > 40)
				break;
		end
		repeat (3) @(posedge hclk);
		check(i_spch_host.q.size(), e.len());
		for (int i = 0; i < e.len() && i < i_spch_host.q.size(); i++)
			check(i_spch_host.q[i], e[i]);
		i_spch_host.q.delete();
		$display("test %s done", f.substr(0, f.len()-2));
	endtask : cmd

	task final_report;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, REG_CFG, 32'h0);
		check(rd, 32'h0);
		ahb(1'b1, REG_CFG, 32'h3);
		ahb(1'b0, REG_CFG, 32'h0);
		check(rd, 32'h3);
		ahb(1'b1, 8'h10, 32'h5A);
		ahb(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		port_in.user         <= 8'hA5;
		port_in.cover_closed <= 1'b1;
		port_in.expander     <= 8'h3C;
		port_in.limit        <= 4'hF;
		cmd("@3b0\r", "0A5");
		cmd("@3b65531\r", "0A5");
		cmd("@3b1\r", "001");
		cmd("@3b5\r", "03C");
		i_spch_host.slow <= 1'b1;
		cmd("@3B0,255\r", "0");
		check(port_out.user, 8'h78);
		cmd("@3B65529,0\r", "0");
		check(port_out.user, 8'h00);
		i_spch_host.slow <= 1'b0;
		cmd("@3B2,2\r", "E");
		check(port_out.spindle, 1'b0);
		cmd("@3B2,1\r", "0");
		check(port_out.spindle, 1'b1);
		cmd("@3B1,1\r", "0");
		check(port_out.cover_release, 1'b1);
		cmd("@3B4,128\r", "0");
		check(port_out.analog, 8'h80);
		cmd("@3B5,7\r", "0");
		check(port_out.expander, 8'h07);
		check(exp_pulses, 32'h1);
		ahb(1'b0, REG_PORTS, 32'h0);
		check(rd, 32'h0080_0003);
		cmd("@0b0\r", "");
		motion_busy <= 1'b1;
		cmd("@3b0\r", "E");
		cmd("@3B3,1\r", "E");
		check(port_out.motor, 1'b0);
		cmd("@3T1\r", "E");
		motion_busy <= 1'b0;
		cmd("@3T1\r", "0");
		check(test_mode, 1'b1);
		check(limit_block, 4'h0);
		check(limit_seen, 4'hF);
		ahb(1'b0, REG_STATUS, 32'h0);
		check(rd & 32'h1, 32'h1);
		@(posedge hclk);
		ref_req <= 1'b1;
		@(posedge hclk);
		ref_req <= 1'b0;
		#1;
		check({ref_capture, home_start}, 2'b10);
		cmd("@3T0\r", "0");
		check({test_mode, limit_block}, 5'h0F);
		port_in.limit <= 4'h5;
		cmd("@3h\r", "L05\r\n0");
		cmd("@3H\r", "IA5\r\n0");
		final_report();
	end

	initial begin
		#300000;
		mismatches++;
		final_report();
	end
endmodule : spch_top_tb
